// >>> csr_access_unit.v
// Execution logic for the atomic register swap, set-bits and clear-bits
// instructions of one hardware thread.
// Assumes the pipeline holds i_issue_valid with a stable instruction until
// o_issue_ready, and the register file answers a read in the same cycle.
`timescale 1ns/10ps
`include "csr_access_unit_regs.vh"

//Contract
// - Swap skips zero-dest read; set/clear write conditional
// - Swap triggers every field's write side effects
// - Set/clear triggers fields hit by mask
// - Value-caused consequences are not write side effects
// - Only custom registers have read side effects
// - Read returns value before this instruction
// - Explicit write replaces implicit update
// - Access ordered after earlier, before later
// - Side effects visible to next instruction only
// - No memory ordering unless dependency applies
// - Reads class input, writes class output
// - Implicit external reads ordered as input
// - Strongly ordered registers wait for weak/IO
// - Specifier is instruction bits 31-20
// - Old value zero-extended to integer width
// - Immediate is 5-bit zero-extended source field
// - Set/clear change only masked writable bits
module csr_access_unit #(
    parameter INT_WIDTH = 32,                    // Integer register width
    parameter REG_WIDTH = 32,                    // Register width, <= INT_WIDTH
    parameter NF        = 4                      // Fields per register
) (
    input  wire                 i_clock,         // Core clock
    input  wire                 i_rst_b,         // Async reset, active low
    input  wire                 i_issue_valid,   // Instruction offered
    input  wire [31:0]          i_instr,         // Instruction word
    input  wire [INT_WIDTH-1:0] i_src_val,       // Value of the source register
    input  wire                 i_older_pending, // Earlier state-affecting work open
    input  wire                 i_mem_dep,       // Memory dependency applies
    input  wire                 i_mem_pending,   // Earlier memory access open
    input  wire                 i_strong,        // Addressed register strongly ordered
    input  wire                 i_weak_pending,  // Weak register or IO access open
    input  wire                 i_custom,        // Addressed register is custom
    input  wire                 i_implicit_read, // Implicit external register read
    input  wire [REG_WIDTH-1:0] i_csr_rdata,     // Register file read data
    input  wire [REG_WIDTH-1:0] i_wr_mask,       // Writable bits of register
    input  wire [NF*REG_WIDTH-1:0] i_field_map,  // Field bit maps
    output reg                  o_issue_ready,   // Instruction taken
    output reg                  o_unsupported,   // Not a register access form
    output reg                  o_busy,          // Access in flight
    output reg  [`SPEC_WIDTH-1:0] o_csr_addr,    // Register specifier
    output reg                  o_csr_lock,      // Hold off other accesses
    output reg                  o_csr_rd_en,     // Explicit read strobe
    output reg                  o_read_fx,       // Read side-effect strobe
    output reg                  o_csr_wr_en,     // Whole-register write strobe
    output reg  [REG_WIDTH-1:0] o_csr_wdata,     // New register value
    output reg  [NF-1:0]        o_field_fx,      // Field write side-effect strobes
    output reg                  o_hold_implicit, // Defer implicit updates
    output reg                  o_suppress_implicit, // Drop implicit update
    output reg                  o_class_in,      // Access counts as device input
    output reg                  o_class_out,     // Access counts as device output
    output reg                  o_dest_we,       // Destination write strobe
    output reg  [4:0]           o_dest_idx,      // Destination register index
    output reg  [INT_WIDTH-1:0] o_dest_data,     // Old value, zero-extended
    output reg                  o_done           // Access complete
);

    // ****************************************************************
    // Decode helper
    // ****************************************************************
    // Maps the low two of the three operation bits to the access kind
    function [1:0] op_kind;
        input [2:0] op;
        begin
            case (op[1:0])
                2'h1:    op_kind = `KIND_SWAP;
                2'h2:    op_kind = `KIND_SET;
                2'h3:    op_kind = `KIND_CLEAR;
                default: op_kind = `KIND_NONE;
            endcase
        end
    endfunction

    // ****************************************************************
    // Held instruction state
    // ****************************************************************
    reg [`ST_W-1:0]     state;          // One-hot state
    reg [`ST_W-1:0]     next_state;     // Next state
    reg [1:0]           kind;           // Access kind
    reg [REG_WIDTH-1:0] operand;        // Mask or new value
    reg                 do_read;        // Read happens
    reg                 do_write;       // Write happens
    reg [REG_WIDTH-1:0] old_val;        // Captured old value

    // Combinational decode of the offered instruction
    wire [2:0]           op      = i_instr[`OP_HI:`OP_LO];
    wire [1:0]           dec     = op_kind(op);
    wire [4:0]           src_fld = i_instr[`SRC_HI:`SRC_LO];
    wire [4:0]           dst_fld = i_instr[`DEST_HI:`DEST_LO];
    wire                 is_sys  = (i_instr[`OPCODE_HI:`OPCODE_LO] == `OPCODE_SYSTEM);
    wire [INT_WIDTH-1:0] imm_ext = {{(INT_WIDTH-`SRC_WIDTH){1'b0}}, src_fld};
    wire [INT_WIDTH-1:0] opnd    = op[`OP_IMM_BIT] ? imm_ext : i_src_val;
    wire                 take    = (state == `ST_IDLE) & i_issue_valid & ~o_issue_ready;

    // Swap reads unless dest is zero; set/clear write unless operand field zero
    wire dec_read  = (dec == `KIND_SWAP) ? (dst_fld != `ZERO_REG) : 1'b1;
    wire dec_write = (dec == `KIND_SWAP) ? 1'b1 : (src_fld != `ZERO_REG);

    // Ordering gate: earlier state work, memory dependency, strong ordering
    wire order_ok = ~i_older_pending
                  & ~(i_mem_dep & i_mem_pending)
                  & ~(i_strong & i_weak_pending);

    // Value read in this cycle; zero when the form skips the read.
    // The new value is built from it directly, since old_val only
    // takes it at the same edge that launches the write.
    wire [REG_WIDTH-1:0] rd_val = do_read ? i_csr_rdata : {REG_WIDTH{1'b0}};

    // New value: swap replaces, set/clear touch only masked writable bits
    reg [REG_WIDTH-1:0] next_wdata;
    always @* begin
        case (kind)
            `KIND_SWAP:  next_wdata = operand;
            `KIND_SET:   next_wdata = rd_val | (operand & i_wr_mask);
            `KIND_CLEAR: next_wdata = rd_val & ~(operand & i_wr_mask);
            default:     next_wdata = rd_val;
        endcase
    end

    // Old value widened to the integer width, upper bits zero
    reg [INT_WIDTH-1:0] old_ext;
    always @* begin
        old_ext                = {INT_WIDTH{1'b0}};
        old_ext[REG_WIDTH-1:0] = old_val;
    end

    // Field strobes depend only on the mask, never on the resulting value
    wire [NF-1:0] field_fx;
    csr_field_effects #(
        .NF (NF),
        .W  (REG_WIDTH)
    ) csr_field_effects_inst (
        .i_field_map (i_field_map),
        .i_mask      (operand),
        .i_swap      (kind == `KIND_SWAP),
        .i_write     (do_write),
        .o_field_fx  (field_fx)
    );

    // ****************************************************************
    // State sequencing
    // ****************************************************************
    // Next-state logic
    always @* begin
        next_state = state;
        case (state)
            // Wait for an offered register access
            `ST_IDLE: begin
                if (take && is_sys && dec != `KIND_NONE)
                    next_state = `ST_ORDER;
            end
            // Wait for earlier work to settle
            `ST_ORDER: begin
                if (order_ok)
                    next_state = `ST_READ;
            end
            `ST_READ:  next_state = `ST_WRITE;
            `ST_WRITE: next_state = `ST_DONE;
            `ST_DONE:  next_state = `ST_IDLE;
            default:   next_state = `ST_IDLE;
        endcase
    end

    // State register and held instruction
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state    <= `ST_IDLE;
            kind     <= `KIND_NONE;
            operand  <= {REG_WIDTH{1'b0}};
            do_read  <= 1'b0;
            do_write <= 1'b0;
            old_val  <= {REG_WIDTH{1'b0}};
        end else begin
            state <= next_state;
            // Latch the decoded access when taken
            if (state == `ST_IDLE && next_state == `ST_ORDER) begin
                kind     <= dec;
                operand  <= opnd[REG_WIDTH-1:0];
                do_read  <= dec_read;
                do_write <= dec_write;
            end
            // Old value sampled before any implicit update of this instruction
            if (state == `ST_READ)
                old_val <= do_read ? i_csr_rdata : {REG_WIDTH{1'b0}};
        end
    end

    // ****************************************************************
    // Output flops
    // ****************************************************************
    // All outputs registered; strobes last one cycle
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_issue_ready       <= 1'b0;
            o_unsupported       <= 1'b0;
            o_busy              <= 1'b0;
            o_csr_addr          <= {`SPEC_WIDTH{1'b0}};
            o_csr_lock          <= 1'b0;
            o_csr_rd_en         <= 1'b0;
            o_read_fx           <= 1'b0;
            o_csr_wr_en         <= 1'b0;
            o_csr_wdata         <= {REG_WIDTH{1'b0}};
            o_field_fx          <= {NF{1'b0}};
            o_hold_implicit     <= 1'b0;
            o_suppress_implicit <= 1'b0;
            o_class_in          <= 1'b0;
            o_class_out         <= 1'b0;
            o_dest_we           <= 1'b0;
            o_dest_idx          <= 5'h00;
            o_dest_data         <= {INT_WIDTH{1'b0}};
            o_done              <= 1'b0;
        end else begin
            // Taken pulse, and rejection of other forms
            o_issue_ready <= take;
            o_unsupported <= take & ~(is_sys & (dec != `KIND_NONE));
            // Busy from acceptance until completion, so later ones wait
            o_busy        <= (next_state != `ST_IDLE);
            if (state == `ST_IDLE && next_state == `ST_ORDER) begin
                o_csr_addr <= i_instr[`SPEC_HI:`SPEC_LO];
                o_dest_idx <= dst_fld;
            end
            // Lock spans read through write so nothing slips between
            o_csr_lock <= (next_state == `ST_READ) | (next_state == `ST_WRITE);
            // Read strobe in the read cycle only when the form reads
            o_csr_rd_en <= (next_state == `ST_READ) & do_read;
            // Read side effects only for custom registers
            o_read_fx   <= (next_state == `ST_READ) & do_read & i_custom;
            // Implicit updates held off while the access is in flight
            o_hold_implicit <= (next_state != `ST_IDLE);
            // Write cycle: whole-register and field strobes
            o_csr_wr_en <= (state == `ST_READ) & do_write;
            o_csr_wdata <= next_wdata;
            o_field_fx  <= (state == `ST_READ) ? field_fx : {NF{1'b0}};
            o_suppress_implicit <= (state == `ST_READ) & do_write;
            // Barrier classes: explicit reads and implicit reads are input
            o_class_in  <= ((next_state == `ST_READ) & do_read) | i_implicit_read;
            o_class_out <= (state == `ST_READ) & do_write;
            // Result after the write, visible to the next instruction only
            o_dest_we   <= (state == `ST_WRITE) & (o_dest_idx != `ZERO_REG);
            o_dest_data <= old_ext;
            o_done      <= (state == `ST_WRITE);
        end
    end

endmodule

// >>> csr_access_unit_props.sv
// Checker for the register access unit, attached to its top ports.
// Assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module csr_access_unit_props #(parameter NF = 4) (
    input wire          i_clock, i_rst_b, i_issue_valid,
    input wire [31:0]   i_instr,
    input wire          i_older_pending, i_mem_dep, i_mem_pending,
    input wire          i_strong, i_weak_pending, i_implicit_read,
    input wire          o_issue_ready, o_unsupported, o_busy, o_csr_lock,
    input wire          o_csr_rd_en, o_read_fx, o_csr_wr_en, o_suppress_implicit,
    input wire          o_class_in, o_class_out, o_dest_we, o_done,
    input wire [11:0]   o_csr_addr,
    input wire [NF-1:0] o_field_fx,
    input wire [4:0]    o_dest_idx
);
// ****************************************************************
// Helper logic
// ****************************************************************
default clocking @(posedge i_clock); endclocking
default disable iff (!i_rst_b);
reg  [31:0] ins;                                 // Word of the access in flight
wire take  = i_issue_valid && !o_busy && !o_issue_ready && !o_done;
wire sw    = ins[13:12] == 2'h1;                 // Swap form
wire rd_z  = ins[11:7] == 5'h00;                 // Destination is zero_reg
wire src_z = ins[19:15] == 5'h00;                // Source field is zero
wire gate  = i_older_pending || (i_mem_dep && i_mem_pending) || (i_strong && i_weak_pending);
// Capture the word on the edge that takes it
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) ins <= 32'h0;
    else if (take) ins <= i_instr;
end
// ****************************************************************
// Properties
// ****************************************************************
property p_take; take |=> o_issue_ready; endproperty
a_take: assert property (p_take) else $error("offer not taken");
property p_spec; o_issue_ready && !o_unsupported |-> o_csr_addr == ins[31:20]; endproperty
a_spec: assert property (p_spec) else $error("wrong specifier");
property p_rd; $rose(o_csr_lock) |-> o_csr_rd_en == !(sw && rd_z); endproperty
a_rd: assert property (p_rd) else $error("wrong read decision");
property p_wr; $rose(o_csr_lock) |=> o_csr_wr_en == (sw || !src_z); endproperty
a_wr: assert property (p_wr) else $error("wrong write decision");
property p_fld; o_csr_wr_en && sw |-> &o_field_fx; endproperty
a_fld: assert property (p_fld) else $error("swap missed a field");
property p_rfx; o_read_fx |-> o_csr_rd_en; endproperty
a_rfx: assert property (p_rfx) else $error("read effect without read");
property p_sup; o_csr_wr_en |-> o_suppress_implicit && o_class_out; endproperty
a_sup: assert property (p_sup) else $error("write not overriding");
property p_cls; o_csr_rd_en || $past(i_implicit_read) |-> o_class_in; endproperty
a_cls: assert property (p_cls) else $error("input class missing");
property p_gate; gate |=> !$rose(o_csr_lock); endproperty
a_gate: assert property (p_gate) else $error("access ran early");
property p_atom; $rose(o_csr_lock) |=> o_csr_lock ##1 (!o_csr_lock && o_done); endproperty
a_atom: assert property (p_atom) else $error("access not atomic");
property p_bound; o_issue_ready && !o_unsupported |-> ##[3:60] o_done; endproperty
a_bound: assert property (p_bound) else $error("access never done");
property p_dest; o_dest_we |-> o_done && o_dest_idx == ins[11:7] && !rd_z; endproperty
a_dest: assert property (p_dest) else $error("bad destination write");
c_swap: cover property (o_csr_wr_en && sw);
c_nowr: cover property ($rose(o_csr_lock) ##1 !o_csr_wr_en);
c_rfx: cover property (o_read_fx);
c_unsup: cover property (o_unsupported);
endmodule

bind csr_access_unit csr_access_unit_props #(.NF(NF)) csr_access_unit_props_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_issue_valid(i_issue_valid),
    .i_instr(i_instr), .i_older_pending(i_older_pending), .i_mem_dep(i_mem_dep),
    .i_mem_pending(i_mem_pending), .i_strong(i_strong), .i_weak_pending(i_weak_pending),
    .i_implicit_read(i_implicit_read), .o_issue_ready(o_issue_ready),
    .o_unsupported(o_unsupported), .o_busy(o_busy), .o_csr_lock(o_csr_lock),
    .o_csr_rd_en(o_csr_rd_en), .o_read_fx(o_read_fx), .o_csr_wr_en(o_csr_wr_en),
    .o_suppress_implicit(o_suppress_implicit), .o_class_in(o_class_in),
    .o_class_out(o_class_out), .o_dest_we(o_dest_we), .o_done(o_done),
    .o_csr_addr(o_csr_addr), .o_field_fx(o_field_fx), .o_dest_idx(o_dest_idx));

// >>> csr_access_unit_regs.vh
// Constants for the register access unit: instruction fields, operation
// codes, state codes and operand sizes.
// Assumes it is included by bare name from the design modules only.
`ifndef CSR_ACCESS_UNIT_REGS_VH
`define CSR_ACCESS_UNIT_REGS_VH

// ****************************************************************
// Instruction field positions
// ****************************************************************
`define SPEC_HI        31
`define SPEC_LO        20
`define SPEC_WIDTH     12
`define SRC_HI         19
`define SRC_LO         15
`define SRC_WIDTH      5
`define OP_HI          14
`define OP_LO          12
`define DEST_HI        11
`define DEST_LO        7
`define OPCODE_HI      6
`define OPCODE_LO      0
`define OP_IMM_BIT     2

// ****************************************************************
// Operation codes
// ****************************************************************
`define OPCODE_SYSTEM  7'h73
`define ZERO_REG       5'h00
`define KIND_NONE      2'h0
`define KIND_SWAP      2'h1
`define KIND_SET       2'h2
`define KIND_CLEAR     2'h3

// ****************************************************************
// One-hot states
// ****************************************************************
`define ST_W           5
`define ST_IDLE        5'h01
`define ST_ORDER       5'h02
`define ST_READ        5'h04
`define ST_WRITE       5'h08
`define ST_DONE        5'h10

`endif

// >>> csr_access_unit_tb.sv
// Self-checking bench for the register access unit.
// Assumes pipe_model and the checker are compiled beside the design.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
    n_mismatch = n_mismatch + 1; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module csr_access_unit_tb;
localparam [127:0] FMAP = 128'hFF000000_00FF0000_0000FF00_000000FF;
logic i_clock = 0, i_rst_b = 0, start = 0, imp = 0, custom = 0, rs, ws, fxr;
logic [31:0] word = 0, src = 0, csr = 0, mask = 0, wd, rnd;
logic [3:0] g = 0, fx;
logic [2:0] wt = 0;
integer seed = 53520, n_mismatch = 0, n_tests = 0, i;
wire valid, older, ready, unsup, busy, lock, rd_en, rfx, wr_en, supp, hold, cin, cout, dwe, done;
wire [31:0] instr, wdata, ddata;
wire [11:0] addr;
wire [3:0] ffx;
wire [4:0] didx;
always #4 i_clock = ~i_clock;
pipe_model pipe_model_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(start),
    .i_word(word), .i_wait(wt), .i_issue_ready(ready), .o_issue_valid(valid),
    .o_instr(instr), .o_older(older));
csr_access_unit csr_access_unit_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_issue_valid(valid), .i_instr(instr), .i_src_val(src), .i_older_pending(older),
    .i_mem_dep(g[0]), .i_mem_pending(older & g[1]), .i_strong(g[2]),
    .i_weak_pending(older & g[3]), .i_custom(custom), .i_implicit_read(imp),
    .i_csr_rdata(lock ? csr : ~csr), .i_wr_mask(mask), .i_field_map(FMAP),
    .o_issue_ready(ready), .o_unsupported(unsup), .o_busy(busy), .o_csr_addr(addr),
    .o_csr_lock(lock), .o_csr_rd_en(rd_en), .o_read_fx(rfx), .o_csr_wr_en(wr_en),
    .o_csr_wdata(wdata), .o_field_fx(ffx), .o_hold_implicit(hold),
    .o_suppress_implicit(supp), .o_class_in(cin), .o_class_out(cout), .o_dest_we(dwe),
    .o_dest_idx(didx), .o_dest_data(ddata), .o_done(done));
// Record strobes of the access in flight and drive implicit reads
always @(posedge i_clock) begin
    imp <= i_rst_b & ($random(seed) < 0);
    if (rd_en) rs <= 1'b1;
    if (rfx) fxr <= 1'b1;
    if (wr_en) begin
        ws <= 1'b1;
        wd <= wdata;
        fx <= ffx;
    end
end
// Word builder, optionally with zero destination or zero source field
function [31:0] mk(input [2:0] f, input zd, input zs);
    reg [31:0] r;
    begin
        r = $random(seed);
        mk = {r[31:20], zs ? 5'h00 : r[19:15] | 5'h01, f, zd ? 5'h00 : r[11:7] | 5'h01, 7'h73};
    end
endfunction
// One access: offer, wait, compare against the bench model
task op(input [31:0] w, input [31:0] s);
    reg [31:0] opd, ex, old, cm;
    reg [63:0] rr;
    reg rdx, wrx, bad;
    integer k;
    begin
        rr = {$random(seed), $random(seed)};
        @(posedge i_clock);
        {word, src, start, rs, ws, fxr} <= {w, s, 4'h8};
        {wt, g, custom, mask} <= rr[39:0];
        @(posedge i_clock);
        start <= 1'b0;
        k = 0;
        while (done !== 1'b1 && unsup !== 1'b1 && k < 100) begin
            @(negedge i_clock);
            k = k + 1;
        end
        if (k >= 100) n_mismatch = n_mismatch + 1;
        bad = w[6:0] != 7'h73 || w[13:12] == 2'h0;
        `CHK(unsup, bad)
        if (!bad) begin
            opd = w[14] ? {27'h0, w[19:15]} : s;
            rdx = w[13:12] != 2'h1 || w[11:7] != 5'h00;
            wrx = w[13:12] == 2'h1 || w[19:15] != 5'h00;
            old = csr;
            ex = w[13:12] == 2'h1 ? opd : w[13:12] == 2'h2 ? old | opd : old & ~opd;
            ex = (old & ~mask) | (ex & mask);
            cm = w[13:12] == 2'h1 ? mask : 32'hFFFFFFFF;
            `CHK(rs, rdx)
            `CHK(ws, wrx)
            `CHK(fxr, rdx & custom)
            `CHK(addr, w[31:20])
            `CHK(didx, w[11:7])
            `CHK(hold, 1'b1)
            `CHK(dwe, w[11:7] != 5'h00)
            `CHK(ddata, rdx ? old : 32'h0)
            if (wrx) begin
                `CHK(wd & cm, ex & cm)
                `CHK(fx, w[13:12] == 2'h1 ? 4'hF : {|opd[31:24], |opd[23:16], |opd[15:8], |opd[7:0]})
                csr = (csr & ~mask) | (wd & mask);
            end
        end
    end
endtask
task report_and_stop;
    begin
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
endtask
// Watchdog against a hung handshake
initial begin
    #160000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
end
// Corner forms first, then random traffic
initial begin
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (i = 0; i < 32; i = i + 1) op(mk(i[4:2], i[0], i[1]), i[2] ? 32'h0 : $random(seed));
    op(32'h00001013, 32'h0);
    for (i = 0; i < 150; i = i + 1) begin
        rnd = $random(seed);
        op(mk(rnd[2:0], rnd[3], rnd[4]), $random(seed));
    end
    report_and_stop;
end
endmodule

// >>> csr_field_effects.v
// Per-field write side-effect strobes for one register write.
// Assumes the register file supplies one bit map per field of the
// addressed register, field f in bits [f*W +: W].
`timescale 1ns/10ps

module csr_field_effects #(
    parameter NF = 4,                         // Fields per register
    parameter W  = 32                         // Register width
) (
    input  wire [NF*W-1:0] i_field_map,       // Bit map of every field
    input  wire [W-1:0]    i_mask,            // Operand used as the mask
    input  wire            i_swap,            // Swap form
    input  wire            i_write,           // Write really happens
    output wire [NF-1:0]   o_field_fx         // Field side-effect strobes
);

    // ****************************************************************
    // One strobe per field
    // ****************************************************************
    genvar f;
    generate
        for (f = 0; f < NF; f = f + 1) begin : g_field
            // Swap touches every field; set/clear only fields hit by the mask
            assign o_field_fx[f] = i_write &
                (i_swap | (|(i_mask & i_field_map[f*W +: W])));
        end
    endgenerate

endmodule

// >>> pipe_model.sv
// Pipeline model: offers one word and holds it until it is taken.
// Assumes the bench pulses i_start only while no offer is open.
`timescale 1ns/10ps
module pipe_model (
    input  wire        i_clock,
    input  wire        i_rst_b,
    input  wire        i_start,
    input  wire [31:0] i_word,
    input  wire [2:0]  i_wait,
    input  wire        i_issue_ready,
    output reg         o_issue_valid,
    output reg  [31:0] o_instr,
    output wire        o_older
);
reg [2:0] cnt;                         // Cycles of earlier work left
assign o_older = cnt != 3'h0;
// Offer, hold until ready, then scramble the idle word
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_issue_valid <= 1'b0;
        o_instr <= 32'h0;
        cnt <= 3'h0;
    end else if (i_start) begin
        o_issue_valid <= 1'b1;
        o_instr <= i_word;
        cnt <= i_wait;
    end else begin
        if (i_issue_ready) o_issue_valid <= 1'b0;
        if (!o_issue_valid) o_instr <= ~o_instr;
        if (o_older) cnt <= cnt - 3'h1;
    end
end
endmodule
